// File: logic/irq_ctrl.sv
// Purpose: interrupt request flags, enables, priority and vector hand-off
// Assumes: core drives pc/stack signals on clk; ext pins are asynchronous
// Notes:   sources by priority 0..8: ext0..3, cmp0, cmp1, mf2, mf3, mf4
// Notes on behaviour
// [R1] comparator and group events set their flag whatever the enable says; pin events need the pin enable
// [R2] a set flag vectors only while its own enable is 1
// [R3] global enable at 0 blocks every interrupt
// [R4] on taking, push next pc and load the vector address
// [R5] return instruction pops saved pc; software ends routines with it
// [R6] servicing clears the global enable, stopping nesting
// [R7] requests while blocked still set and hold flags
// [R8] software may set global enable again inside a routine to nest
// [R9] full stack blocks acknowledge until the pointer drops
// [R10] simultaneous enabled requests resolve by fixed priority
// [R11] a new flag set wakes from sleep or idle; old flags do not
// [R12] each external pin sets its flag on the selected edge
// [R13] external call needs global and pin enable plus non-full stack
// [R14] edge select offers rising, falling, both or disabled
// [R15] pin serves as interrupt input only while its enable is set
// [R16] servicing an external interrupt clears that pin flag
// [R17] pin pull-high selection stays in effect in interrupt use
// [R18] comparator flag sets when its comparator output changes
// [R19] comparator call needs global and own enable; service clears flag
// [R20] flags 1 pending, enables 1 on, all reset to zero
// [R21] group service clears only group flag, sub-flags stay
// [R22] external pins pass two flip-flops before edge detection
// [R23] service clear beats a set only for the serviced source
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module irq_ctrl #(
   parameter int PC_W = irq_ctrl_pkg::PC_W
) (
   input  wire logic                               clk,
   input  wire logic                               rst,
   input  wire logic [irq_ctrl_pkg::ADDR_W-1:0]    reg_addr,
   input  wire logic [irq_ctrl_pkg::DATA_W-1:0]    reg_wdata,
   input  wire logic                               reg_wr,
   input  wire logic                               reg_rd,
   output logic      [irq_ctrl_pkg::DATA_W-1:0]    reg_rdata,
   input  wire logic [irq_ctrl_pkg::NUM_EXT-1:0]   ext_irq_pins,
   input  wire logic [irq_ctrl_pkg::NUM_EXT-1:0]   pin_pull_sel,
   output logic      [irq_ctrl_pkg::NUM_EXT-1:0]   pin_pull_en,
   input  wire logic [irq_ctrl_pkg::NUM_CMP-1:0]   cmp_out,
   input  wire logic [3:0]                         mf2_events,
   input  wire logic [2:0]                         mf3_events,
   input  wire logic [3:0]                         mf4_events,
   input  wire logic                               core_ready,
   input  wire logic [PC_W-1:0]                    next_pc,
   input  wire logic                               stack_full,
   input  wire logic                               return_from_irq,
   input  wire logic [PC_W-1:0]                    popped_pc,
   input  wire logic                               low_power,
   output logic                                    irq_take,
   output logic      [PC_W-1:0]                    vector_addr,
   output logic                                    stack_push,
   output logic      [PC_W-1:0]                    push_pc,
   output logic                                    pc_load,
   output logic      [PC_W-1:0]                    pc_value,
   output logic                                    wake_up
);
   localparam int NS = irq_ctrl_pkg::NUM_SRC;

   logic                                   global_irq_enable_r;
   logic [irq_ctrl_pkg::NUM_EXT-1:0]       ext_pin_flags_r;
   logic [irq_ctrl_pkg::NUM_EXT-1:0]       ext_pin_enables_r;
   logic [7:0]                             edge_select_reg_r;
   logic [irq_ctrl_pkg::NUM_CMP-1:0]       cmp_flag_r;
   logic [irq_ctrl_pkg::NUM_CMP-1:0]       cmp_en_r;
   logic [2:0]                             mf_flag_r;
   logic [2:0]                             mf_en_r;
   logic [7:0]                             mf2_r;
   logic [7:0]                             mf3_r;
   logic [7:0]                             mf4_r;
   logic [irq_ctrl_pkg::NUM_EXT-1:0]       pin_meta_r;
   logic [irq_ctrl_pkg::NUM_EXT-1:0]       pin_sync_r;
   logic [irq_ctrl_pkg::NUM_EXT-1:0]       pin_prev_r;
   logic [irq_ctrl_pkg::NUM_CMP-1:0]       cmp_prev_r;
   logic [1:0]                             settle_cnt_r;
   logic                                   sync_valid;
   logic                                   cmp_armed;
   logic [NS-1:0]                          any_flag_prev_r;
   logic [irq_ctrl_pkg::SRC_W-1:0]         last_src_r;
   logic [irq_ctrl_pkg::DATA_W-1:0]        reg_rdata_nxt;
   logic [irq_ctrl_pkg::NUM_EXT-1:0]       ext_hit;
   logic [irq_ctrl_pkg::NUM_CMP-1:0]       cmp_hit;
   logic [2:0]                             mf_hit;
   logic [NS-1:0]                          flags;
   logic [NS-1:0]                          enables;
   logic [NS-1:0]                          pending;
   logic [NS-1:0]                          svc_clr;
   logic [irq_ctrl_pkg::SRC_W-1:0]         win_src;
   logic                                   win_any;
   logic                                   take;
   logic                                   wr_ctrl;
   logic                                   wr_main;
   logic                                   wr_ext;

   assign wr_ctrl = reg_wr && (reg_addr == irq_ctrl_pkg::CTRL_OFF);
   assign wr_main = reg_wr && (reg_addr == irq_ctrl_pkg::MAIN_OFF);
   assign wr_ext  = reg_wr && (reg_addr == irq_ctrl_pkg::EXT_OFF);

   // two-stage pin synchroniser; edge logic reads the second stage and its delayed copy pin_prev_r
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_meta_r <= '0;
         pin_sync_r <= '0;
         pin_prev_r <= '0;
      end else begin
         pin_meta_r <= ext_irq_pins;         // R22
         pin_sync_r <= pin_meta_r;           // R22
         pin_prev_r <= pin_sync_r;
      end
   end

   // a pin idling high would fake a rising edge until sync and prev both
   // hold real samples; comparators need one real sample only
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         settle_cnt_r <= 2'h0;
      else if (settle_cnt_r != 2'h3)
         settle_cnt_r <= settle_cnt_r + 2'h1;
   end
   assign sync_valid = (settle_cnt_r == 2'h3);
   assign cmp_armed  = (settle_cnt_r != 2'h0);

   // edge decode per pin; pin unused as interrupt input unless enabled
   genvar g;
   generate
      for (g = 0; g < irq_ctrl_pkg::NUM_EXT; g++) begin : g_ext
         logic [1:0] sel;
         logic       rise;
         logic       fall;
         logic       hit_sel;
         assign sel  = edge_select_reg_r[2*g +: 2];
         assign rise = pin_sync_r[g] && !pin_prev_r[g];
         assign fall = !pin_sync_r[g] && pin_prev_r[g];
         always_comb begin
            case (sel)                                                   // R14
               irq_ctrl_pkg::EDGE_RISE: hit_sel = rise;
               irq_ctrl_pkg::EDGE_FALL: hit_sel = fall;
               irq_ctrl_pkg::EDGE_BOTH: hit_sel = rise || fall;
               default:                 hit_sel = 1'b0;
            endcase
         end
         assign ext_hit[g] = hit_sel && ext_pin_enables_r[g] && sync_valid; // R12 R15
      end
   endgenerate

   // pull-high stays whatever the pin is used for
   assign pin_pull_en = pin_pull_sel; // R17

   // comparator outputs come from on-chip logic on clk
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         cmp_prev_r <= '0;
      else
         cmp_prev_r <= cmp_out;
   end
   // first cycle after reset has no real previous comparator sample
   assign cmp_hit = cmp_armed ? (cmp_out ^ cmp_prev_r) : '0; // R18

   // group flag sets on a sub-flag rising
   always_comb begin
      mf_hit[0] = |(mf2_events & ~mf2_r[7:4]);
      mf_hit[1] = |(mf3_events & ~mf3_r[6:4]);
      mf_hit[2] = |(mf4_events & ~mf4_r[7:4]);
   end

   assign flags   = {mf_flag_r, cmp_flag_r, ext_pin_flags_r};
   assign enables = {mf_en_r, cmp_en_r, ext_pin_enables_r};
   assign pending = flags & enables;                                     // R2

   // lowest index wins
   always_comb begin
      win_src = '0;
      win_any = 1'b0;
      for (int i = NS - 1; i >= 0; i--) begin
         if (pending[i]) begin                                           // R10
            win_src = irq_ctrl_pkg::SRC_W'(i);
            win_any = 1'b1;
         end
      end
   end

   // core_ready keeps a take off the cycle in which the core pops
   assign take = win_any && global_irq_enable_r && !stack_full && core_ready; // R3 R9 R13 R19

   always_comb begin
      svc_clr = '0;
      if (take)
         svc_clr[win_src] = 1'b1;                                        // R16 R19 R21
   end

   // hand-off to the core; one-cycle pulses
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_take   <= 1'b0;
         stack_push <= 1'b0;
         pc_load    <= 1'b0;
      end else begin
         irq_take   <= take;
         stack_push <= take;                                             // R4
         pc_load    <= take || return_from_irq;
      end
   end

   // vector from fixed base and step; values hold between loads
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         vector_addr <= '0;
         push_pc     <= '0;
         pc_value    <= '0;
         last_src_r  <= '0;
      end else if (take) begin
         push_pc     <= next_pc;                                         // R4
         vector_addr <= PC_W'(irq_ctrl_pkg::VECTOR_BASE +
                        irq_ctrl_pkg::VECTOR_STEP * win_src);
         pc_value    <= PC_W'(irq_ctrl_pkg::VECTOR_BASE +
                        irq_ctrl_pkg::VECTOR_STEP * win_src);            // R4
         last_src_r  <= win_src;
      end else if (return_from_irq) begin
         pc_value <= popped_pc;                                          // R5
      end
   end

   // global enable: service clear wins over a software write
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         global_irq_enable_r <= 1'b0;                                    // R20
      else if (take)
         global_irq_enable_r <= 1'b0;                                    // R6
      else if (wr_ctrl)
         global_irq_enable_r <= reg_wdata[irq_ctrl_pkg::CTRL_GIE_BIT];
   end

   // flags: hardware set beats software clear; service clear beats own set
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         ext_pin_flags_r <= '0;
      else
         ext_pin_flags_r <= ((wr_ext ? reg_wdata[7:4] : ext_pin_flags_r) | ext_hit)
                            & ~svc_clr[3:0];                             // R1 R7 R23
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         cmp_flag_r <= '0;
      else
         cmp_flag_r <= ((wr_main ? reg_wdata[5:4] : cmp_flag_r) | cmp_hit)
                       & ~svc_clr[5:4];                                  // R1 R7 R23
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         mf_flag_r <= '0;
      else
         mf_flag_r <= ((wr_main ? reg_wdata[3:1] : mf_flag_r) | mf_hit)
                      & ~svc_clr[8:6];                                   // R1 R23
   end

   // enables and edge select change only by software write
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         ext_pin_enables_r <= '0;
      else if (wr_ext)
         ext_pin_enables_r <= reg_wdata[3:0];
   end

   // one common enable bit serves all three groups
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cmp_en_r <= '0;
         mf_en_r  <= '0;
      end else if (wr_main) begin
         cmp_en_r <= reg_wdata[7:6];
         mf_en_r  <= {reg_wdata[0], reg_wdata[0], reg_wdata[0]} & 3'h7;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         edge_select_reg_r <= irq_ctrl_pkg::RESET_VAL;
      else if (reg_wr && reg_addr == irq_ctrl_pkg::EDGE_OFF)
         edge_select_reg_r <= reg_wdata;
   end

   // group registers: upper nibble sub-flags, lower nibble enables;
   // sub-flags are never cleared by servicing
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         mf2_r <= irq_ctrl_pkg::RESET_VAL;
      else
         mf2_r <= ((reg_wr && reg_addr == irq_ctrl_pkg::MF2_OFF) ? reg_wdata : mf2_r)
                  | {mf2_events, 4'h0};                                  // R21
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         mf3_r <= irq_ctrl_pkg::RESET_VAL;
      else
         mf3_r <= (((reg_wr && reg_addr == irq_ctrl_pkg::MF3_OFF) ? reg_wdata : mf3_r)
                  | {1'b0, mf3_events, 4'h0}) & irq_ctrl_pkg::MF3_MASK;  // R21
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         mf4_r <= irq_ctrl_pkg::RESET_VAL;
      else
         mf4_r <= ((reg_wr && reg_addr == irq_ctrl_pkg::MF4_OFF) ? reg_wdata : mf4_r)
                  | {mf4_events, 4'h0};                                  // R21
   end

   // wake only on a flag newly set, not one set before low power
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         any_flag_prev_r <= '0;
         wake_up         <= 1'b0;
      end else begin
         any_flag_prev_r <= flags;
         wake_up         <= low_power && |(flags & ~any_flag_prev_r);    // R11
      end
   end

   always_comb begin
      case (reg_addr)
         irq_ctrl_pkg::CTRL_OFF: reg_rdata_nxt = {7'h00, global_irq_enable_r};
         irq_ctrl_pkg::MAIN_OFF: reg_rdata_nxt = {cmp_en_r, cmp_flag_r, mf_flag_r,
                                                  mf_en_r[0]};           // R20
         irq_ctrl_pkg::EXT_OFF:  reg_rdata_nxt = {ext_pin_flags_r, ext_pin_enables_r};
         irq_ctrl_pkg::EDGE_OFF: reg_rdata_nxt = edge_select_reg_r;
         irq_ctrl_pkg::MF2_OFF:  reg_rdata_nxt = mf2_r;
         irq_ctrl_pkg::MF3_OFF:  reg_rdata_nxt = mf3_r;
         irq_ctrl_pkg::MF4_OFF:  reg_rdata_nxt = mf4_r;
         irq_ctrl_pkg::STAT_OFF: reg_rdata_nxt = {3'h0, win_any, last_src_r};
         irq_ctrl_pkg::VECT_OFF: reg_rdata_nxt = vector_addr[7:0];
         default:                reg_rdata_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         reg_rdata <= '0;
      else if (reg_rd)
         reg_rdata <= reg_rdata_nxt;
      else
         reg_rdata <= '0;
   end
endmodule

// File: logic/irq_ctrl_pkg.sv
// Purpose: constants for the interrupt request controller
// Assumes: 8-bit register port, one system clock
// Notes:   offsets are word indices on the plain register port
package irq_ctrl_pkg;
   localparam int          ADDR_W           = 4;
   localparam int          DATA_W           = 8;
   localparam logic [3:0]  CTRL_OFF         = 4'h0;
   localparam logic [3:0]  MAIN_OFF         = 4'h1;
   localparam logic [3:0]  EXT_OFF          = 4'h2;
   localparam logic [3:0]  EDGE_OFF         = 4'h3;
   localparam logic [3:0]  MF2_OFF          = 4'h4;
   localparam logic [3:0]  MF3_OFF          = 4'h5;
   localparam logic [3:0]  MF4_OFF          = 4'h6;
   localparam logic [3:0]  STAT_OFF         = 4'h7;
   localparam logic [3:0]  VECT_OFF         = 4'h8;
   localparam logic [7:0]  RESET_VAL        = 8'h00;
   localparam logic [7:0]  MF3_MASK         = 8'h77;
   localparam int          CTRL_GIE_BIT     = 0;
   localparam int          CTRL_WAKEARM_BIT = 1;
   localparam int          NUM_EXT          = 4;
   localparam int          NUM_CMP          = 2;
   localparam int          NUM_SRC          = 9;
   localparam int          SRC_W            = 4;
   localparam logic [1:0]  EDGE_OFF_SEL     = 2'h0;
   localparam logic [1:0]  EDGE_RISE        = 2'h1;
   localparam logic [1:0]  EDGE_FALL        = 2'h2;
   localparam logic [1:0]  EDGE_BOTH        = 2'h3;
   localparam int          PC_W             = 15;
   localparam logic [14:0] VECTOR_BASE      = 15'h0004;
   localparam logic [14:0] VECTOR_STEP      = 15'h0004;
endpackage

// File: verif/irq_ctrl_properties.sv
// Purpose: port-level checks for irq_ctrl
// Assumes: one clock, async reset, takes kept apart by the global enable clear on service
// Notes:   flags are internal, so outputs are tied to their port causes
`timescale 1ns/1ps
module irq_ctrl_properties #(
   parameter int PC_W = irq_ctrl_pkg::PC_W
) (
   input wire logic            clk,
   input wire logic            rst,
   input wire logic            reg_rd,
   input wire logic [7:0]      reg_rdata,
   input wire logic [3:0]      pin_pull_sel,
   input wire logic [3:0]      pin_pull_en,
   input wire logic            stack_full,
   input wire logic            core_ready,
   input wire logic [PC_W-1:0] next_pc,
   input wire logic            return_from_irq,
   input wire logic [PC_W-1:0] popped_pc,
   input wire logic            low_power,
   input wire logic            irq_take,
   input wire logic [PC_W-1:0] vector_addr,
   input wire logic            stack_push,
   input wire logic [PC_W-1:0] push_pc,
   input wire logic            pc_load,
   input wire logic [PC_W-1:0] pc_value,
   input wire logic            wake_up
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_take_all; (irq_take || stack_push) |-> irq_take && stack_push && pc_load; endproperty
   a_take_all: assert property (p_take_all) else $error("take pulses differ");
   property p_take_pc; irq_take |-> pc_value == vector_addr; endproperty
   a_take_pc: assert property (p_take_pc) else $error("pc not loaded with vector");
   property p_push; irq_take |-> push_pc == $past(next_pc); endproperty
   a_push: assert property (p_push) else $error("wrong pushed pc");
   property p_vec; irq_take |-> vector_addr[1:0] == 2'h0 && vector_addr >= 4 && vector_addr <= 36; endproperty
   a_vec: assert property (p_vec) else $error("vector outside table");
   property p_full; irq_take |-> !$past(stack_full) && $past(core_ready); endproperty
   a_full: assert property (p_full) else $error("take with full stack");
   property p_no_nest; irq_take |=> !irq_take; endproperty
   a_no_nest: assert property (p_no_nest) else $error("take right after take");
   property p_ret; return_from_irq |=> pc_load && pc_value == $past(popped_pc); endproperty
   a_ret: assert property (p_ret) else $error("return pc not loaded");
   property p_pull; pin_pull_en == pin_pull_sel; endproperty
   a_pull: assert property (p_pull) else $error("pull selection lost");
   property p_wake; wake_up |-> $past(low_power); endproperty
   a_wake: assert property (p_wake) else $error("wake outside low power");
   property p_rdata; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
   a_rdata: assert property (p_rdata) else $error("read data without read");
   c_take: cover property (irq_take && vector_addr == 15'h0008);
   c_ret: cover property (return_from_irq ##1 pc_load);
   c_wake: cover property (wake_up);
endmodule
bind irq_ctrl irq_ctrl_properties #(.PC_W(PC_W)) irq_ctrl_properties_inst (.*);

// File: verif/core_model.sv
// Purpose: core sequencer stand-in: stack, running pc, return
// Assumes: pushes come from irq_ctrl, returns are asked by the bench
// Notes:   shallow stack so the full case is reached at once
`timescale 1ns/1ps
module core_model #(
   parameter int DEPTH = 1
) (
   input  wire logic                          clk,
   input  wire logic                          rst,
   input  wire logic                          do_ret,
   input  wire logic                          stack_push,
   input  wire logic [irq_ctrl_pkg::PC_W-1:0] push_pc,
   output logic                               core_ready,
   output logic      [irq_ctrl_pkg::PC_W-1:0] next_pc,
   output logic                               stack_full,
   output logic                               return_from_irq,
   output logic      [irq_ctrl_pkg::PC_W-1:0] popped_pc
);
   logic [irq_ctrl_pkg::PC_W-1:0] stack_r [DEPTH];
   int                            sp_r;
   logic                          pop;
   assign pop = do_ret && sp_r > 0;
   assign stack_full = sp_r == DEPTH;
   // busy while returning, so a take never lands on the pop
   assign core_ready = !return_from_irq;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         next_pc <= 15'h0000;
         sp_r <= 0;
         return_from_irq <= 1'b0;
         popped_pc <= 15'h0000;
      end else begin
         next_pc <= next_pc + 15'h0001;
         return_from_irq <= pop;
         popped_pc <= pop ? stack_r[sp_r-1] : ~popped_pc;
         if (stack_push) begin
            stack_r[sp_r] <= push_pc;
            sp_r <= sp_r + 1;
         end else if (pop) sp_r <= sp_r - 1;
      end
   end
endmodule

// File: verif/irq_ctrl_tb.sv
// Purpose: register, edge, priority and vector tests for irq_ctrl
// Assumes: core_model holds a one-deep stack
// Notes:   mf3 events stay low; that group is reached by register only
`timescale 1ns/1ps
module irq_ctrl_tb;
   logic        clk, rst, reg_wr, reg_rd, do_ret, low_power, core_ready, stack_full;
   logic        return_from_irq, irq_take, stack_push, pc_load, wake_up;
   logic [3:0]  reg_addr, ext_irq_pins, pin_pull_sel, pin_pull_en, mf2_events, mf4_events;
   logic [7:0]  reg_wdata, reg_rdata;
   logic [2:0]  mf3_events;
   logic [1:0]  cmp_out;
   logic [14:0] next_pc, popped_pc, vector_addr, push_pc, pc_value, last_vec;
   int          bad_count, total_checks, take_cnt, wake_cnt, w0;
   irq_ctrl irq_ctrl_inst (.*);
   core_model core_model_inst (.*);
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(negedge clk) begin
      if (irq_take === 1'b1) begin
         take_cnt++;
         last_vec = vector_addr;
      end
      if (wake_up === 1'b1) wake_cnt++;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
      @(posedge clk) reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk) {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge clk) reg_rd <= 1'b0;
      #1 check({8'h00, reg_rdata}, {8'h00, e});
   endtask
   task automatic pins(input logic [3:0] v);
      @(posedge clk) ext_irq_pins <= v;
      repeat (5) @(posedge clk);
   endtask
   task automatic take(input int want, input logic [14:0] v);
      int n0;
      n0 = take_cnt;
      for (int i = 0; i < 12 && take_cnt == n0; i++) @(posedge clk);
      repeat (2) @(posedge clk);
      check(16'(take_cnt - n0), 16'(want));
      if (want == 1) check({1'b0, last_vec}, {1'b0, v});
   endtask
   // no trailing wait: the take that follows a pop must still be counted
   task automatic ret;
      @(posedge clk) do_ret <= 1'b1;
      @(posedge clk) do_ret <= 1'b0;
   endtask
   task automatic wrap_up;
      if (bad_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #500000;
      bad_count++;
      wrap_up();
   end
   initial begin
      {reg_wr, reg_rd, do_ret, low_power, rst} = 5'h01;
      {reg_addr, reg_wdata, ext_irq_pins, mf2_events, mf3_events, mf4_events, cmp_out} = '0;
      pin_pull_sel = 4'h5;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      for (int a = 0; a < 16; a++) rd(4'(a), 8'h00);
      wr(irq_ctrl_pkg::MF3_OFF, 8'h0f);
      rd(irq_ctrl_pkg::MF3_OFF, 8'h07);
      @(posedge clk) pin_pull_sel <= 4'ha;
      wr(irq_ctrl_pkg::EXT_OFF, 8'h0f);
      for (int m = 0; m < 4; m++) begin
         wr(irq_ctrl_pkg::EDGE_OFF, 8'(m << 6));
         pins(4'h8);
         rd(irq_ctrl_pkg::EXT_OFF, m[0] ? 8'h8f : 8'h0f);
         wr(irq_ctrl_pkg::EXT_OFF, 8'h0f);
         pins(4'h0);
         rd(irq_ctrl_pkg::EXT_OFF, m[1] ? 8'h8f : 8'h0f);
         wr(irq_ctrl_pkg::EXT_OFF, 8'h0f);
      end
      wr(irq_ctrl_pkg::EDGE_OFF, 8'hff);
      wr(irq_ctrl_pkg::EXT_OFF, 8'h00);
      pins(4'h1);
      rd(irq_ctrl_pkg::EXT_OFF, 8'h00);
      wr(irq_ctrl_pkg::EXT_OFF, 8'h01);
      pins(4'h0);
      rd(irq_ctrl_pkg::EXT_OFF, 8'h11);
      take(0, 15'h0000);
      wr(irq_ctrl_pkg::CTRL_OFF, 8'h01);
      take(1, 15'h0004);
      rd(irq_ctrl_pkg::EXT_OFF, 8'h01);
      rd(irq_ctrl_pkg::CTRL_OFF, 8'h00);
      wr(irq_ctrl_pkg::EXT_OFF, 8'h06);
      pins(4'h6);
      wr(irq_ctrl_pkg::CTRL_OFF, 8'h01);
      take(0, 15'h0000);
      ret();
      take(1, 15'h0008);
      rd(irq_ctrl_pkg::EXT_OFF, 8'h46);
      rd(irq_ctrl_pkg::STAT_OFF, 8'h11);
      rd(irq_ctrl_pkg::VECT_OFF, 8'h08);
      ret();
      wr(irq_ctrl_pkg::CTRL_OFF, 8'h01);
      take(1, 15'h000c);
      ret();
      wr(irq_ctrl_pkg::MAIN_OFF, 8'h40);
      @(posedge clk) cmp_out <= 2'h1;
      repeat (4) @(posedge clk);
      rd(irq_ctrl_pkg::MAIN_OFF, 8'h50);
      wr(irq_ctrl_pkg::CTRL_OFF, 8'h01);
      take(1, 15'h0014);
      rd(irq_ctrl_pkg::MAIN_OFF, 8'h40);
      ret();
      @(posedge clk) cmp_out <= 2'h3;
      repeat (4) @(posedge clk);
      rd(irq_ctrl_pkg::MAIN_OFF, 8'h60);
      wr(irq_ctrl_pkg::MAIN_OFF, 8'h01);
      @(posedge clk) mf2_events <= 4'h1;
      @(posedge clk) mf2_events <= 4'h0;
      repeat (3) @(posedge clk);
      rd(irq_ctrl_pkg::MF2_OFF, 8'h10);
      wr(irq_ctrl_pkg::CTRL_OFF, 8'h01);
      take(1, 15'h001c);
      rd(irq_ctrl_pkg::MF2_OFF, 8'h10);
      ret();
      @(posedge clk) low_power <= 1'b1;
      w0 = wake_cnt;
      // second pulse finds the flag already set, so the count must not move
      repeat (2) begin
         @(posedge clk) mf4_events <= 4'h4;
         @(posedge clk) mf4_events <= 4'h0;
         repeat (4) @(posedge clk);
         check(16'(wake_cnt - w0), 16'h0001);
      end
      wrap_up();
   end
endmodule
